// ---- src/cam_pkg.sv ----
// Shared types and constants for the operand addressing decoder.
package cam_pkg;

	// Prefix bytes seen by the core ahead of an opcode.
	localparam logic [7:0] PFX_SECOND_INDEX = 8'h90;
	localparam logic [7:0] PFX_IND_SECOND = 8'h91;
	localparam logic [7:0] PFX_INDIRECT = 8'h92;

	// Upper address byte of page zero.
	localparam logic [7:0] PAGE_ZERO_HI = 8'h00;

	// Field positions and sizes.
	localparam int REL_SIGN_BIT = 7;
	localparam logic [2:0] OPCODE_LEN = 3'h1;

	// Reset values.
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;

	typedef enum logic [4:0] {
		M_INHERENT,
		M_IMMEDIATE,
		M_DIR_SHORT,
		M_DIR_LONG,
		M_IDX_NONE,
		M_IDX_SHORT,
		M_IDX_LONG,
		M_IND_SHORT,
		M_IND_LONG,
		M_INDIDX_SHORT,
		M_INDIDX_LONG,
		M_REL_DIR,
		M_REL_IND,
		M_BIT_DIR,
		M_BIT_IND,
		M_BIT_DIR_REL,
		M_BIT_IND_REL
	} cam_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_PTR,
		ST_CALC
	} cam_state_t;

	// One decode request from the core; pc is the address just after the opcode.
	typedef struct packed {
		cam_mode_t mode;
		logic has_pre;
		logic [7:0] pre;
		logic rmw;
		logic [15:0] pc;
		logic [7:0] idx_x;
		logic [7:0] idx_y;
	} cam_req_t;

	typedef struct packed {
		logic [15:0] ea;
		logic [15:0] target;
		logic [7:0] imm;
		logic [2:0] length;
		logic [15:0] next_pc;
		logic illegal;
	} cam_res_t;

endpackage

// ---- src/cam_addr_decode.sv ----
// Operand addressing mode decoder: fetches operand bytes and forms the effective address.
//
// Summary of operation
// - Short variants give an address whose upper byte is zero, except short indexed and short indirect indexed, which can reach 1FE.
// - Read-modify-write instructions only decode with short variants; long is refused.
// - Inherent instructions are one byte; nothing beyond the opcode is fetched.
// - Immediate instructions are opcode plus one byte holding the operand value.
// - Short direct fetches one address byte used as address 0 to 255.
// - Long direct fetches a two-byte address covering the whole 64 Kbyte space.
// - Indexed address is the unsigned sum of the chosen index register and offset.
// - No-offset indexed fetches nothing and uses the index value as address.
// - Short indexed adds one offset byte to the index, giving up to 1FE.
// - Long indexed adds the index to a two-byte offset over the whole space.
// - Second index register adds one byte to no-offset indexed; first adds none.
// - Relative base is the address of the following instruction.
// - Short indirect fetches a page-zero byte pointer and uses it as address.
// - Long indirect fetches a page-zero word pointer and uses it as address.
// - Relative target is the program counter plus the sign-extended 8-bit offset.
// - Prefix byte 90 turns a first-index instruction into a second-index one.
`timescale 1ns/1ns
module cam_addr_decode (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic req_valid,
	input wire cam_pkg::cam_req_t req,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	output logic mem_rd,
	output logic [15:0] mem_addr,
	output logic busy,
	output logic done,
	output cam_pkg::cam_res_t res
);

	////////////////////////////////////////////////////////////////////////////
	// Mode properties.

	// Bytes taken from the instruction stream after the opcode.
	// A code outside the enum takes one byte, so the fetch sequence still ends.
	function automatic logic [1:0] op_bytes(input cam_pkg::cam_mode_t m);
		logic [1:0] n;
		n = 2'h1;
		unique case (m)
			cam_pkg::M_INHERENT: n = 2'h0;
			cam_pkg::M_IMMEDIATE: n = 2'h1;
			cam_pkg::M_DIR_SHORT: n = 2'h1;
			cam_pkg::M_DIR_LONG: n = 2'h2;
			cam_pkg::M_IDX_NONE: n = 2'h0;
			cam_pkg::M_IDX_SHORT: n = 2'h1;
			cam_pkg::M_IDX_LONG: n = 2'h2;
			cam_pkg::M_IND_SHORT: n = 2'h1;
			cam_pkg::M_IND_LONG: n = 2'h1;
			cam_pkg::M_INDIDX_SHORT: n = 2'h1;
			cam_pkg::M_INDIDX_LONG: n = 2'h1;
			cam_pkg::M_REL_DIR: n = 2'h1;
			cam_pkg::M_REL_IND: n = 2'h1;
			cam_pkg::M_BIT_DIR: n = 2'h1;
			cam_pkg::M_BIT_IND: n = 2'h1;
			// Address or pointer address first, then the signed jump offset.
			cam_pkg::M_BIT_DIR_REL: n = 2'h2;
			cam_pkg::M_BIT_IND_REL: n = 2'h2;
			default: n = 2'h1;
		endcase
		return n;
	endfunction

	// Pointer bytes read from page zero.
	// A code outside the enum reads no pointer.
	function automatic logic [1:0] ptr_bytes(input cam_pkg::cam_mode_t m);
		logic [1:0] n;
		n = 2'h0;
		unique case (m)
			cam_pkg::M_INHERENT: n = 2'h0;
			cam_pkg::M_IMMEDIATE: n = 2'h0;
			cam_pkg::M_DIR_SHORT: n = 2'h0;
			cam_pkg::M_DIR_LONG: n = 2'h0;
			cam_pkg::M_IDX_NONE: n = 2'h0;
			cam_pkg::M_IDX_SHORT: n = 2'h0;
			cam_pkg::M_IDX_LONG: n = 2'h0;
			cam_pkg::M_IND_SHORT: n = 2'h1;
			cam_pkg::M_IND_LONG: n = 2'h2;
			cam_pkg::M_INDIDX_SHORT: n = 2'h1;
			cam_pkg::M_INDIDX_LONG: n = 2'h2;
			cam_pkg::M_REL_DIR: n = 2'h0;
			cam_pkg::M_REL_IND: n = 2'h1;
			cam_pkg::M_BIT_DIR: n = 2'h0;
			cam_pkg::M_BIT_IND: n = 2'h1;
			cam_pkg::M_BIT_DIR_REL: n = 2'h0;
			cam_pkg::M_BIT_IND_REL: n = 2'h1;
			default: n = 2'h0;
		endcase
		return n;
	endfunction

	// The last instruction byte of these modes is a signed jump offset.
	// That byte goes to the jump offset register, never into the address accumulator.
	function automatic logic has_rel(input cam_pkg::cam_mode_t m);
		logic r;
		r = 1'b0;
		unique case (m)
			cam_pkg::M_REL_DIR: r = 1'b1;
			cam_pkg::M_BIT_DIR_REL: r = 1'b1;
			cam_pkg::M_BIT_IND_REL: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Forms that take a 16-bit address, offset or pointer word.
	function automatic logic is_long(input cam_pkg::cam_mode_t m);
		logic r;
		r = 1'b0;
		unique case (m)
			cam_pkg::M_DIR_LONG: r = 1'b1;
			cam_pkg::M_IDX_LONG: r = 1'b1;
			cam_pkg::M_IND_LONG: r = 1'b1;
			cam_pkg::M_INDIDX_LONG: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Effective address once all operand and pointer bytes are in.
	function automatic logic [15:0] form_ea(
		input cam_pkg::cam_mode_t m,
		input logic [15:0] acc,
		input logic [7:0] idx
	);
		logic [8:0] sum9;
		logic [15:0] ea;
		sum9 = {1'b0, idx} + {1'b0, acc[7:0]};
		ea = cam_pkg::RST_WORD;
		unique case (m)
			cam_pkg::M_INHERENT, cam_pkg::M_IMMEDIATE, cam_pkg::M_REL_DIR, cam_pkg::M_REL_IND: begin
				ea = cam_pkg::RST_WORD;
			end
			cam_pkg::M_DIR_LONG, cam_pkg::M_IND_LONG: begin
				ea = acc;
			end
			cam_pkg::M_IDX_NONE: begin
				ea = {cam_pkg::PAGE_ZERO_HI, idx};
			end
			// The ninth bit of the short sum is kept: the operand may sit just above page zero.
			cam_pkg::M_IDX_SHORT, cam_pkg::M_INDIDX_SHORT: begin
				ea = {7'h00, sum9};
			end
			cam_pkg::M_IDX_LONG, cam_pkg::M_INDIDX_LONG: begin
				ea = acc + {cam_pkg::PAGE_ZERO_HI, idx};
			end
			default: begin
				ea = {cam_pkg::PAGE_ZERO_HI, acc[7:0]};
			end
		endcase
		return ea;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		cam_pkg::cam_state_t state;
		cam_pkg::cam_req_t rq;
		logic [7:0] idx;
		logic [15:0] acc;
		logic [7:0] rel;
		logic [1:0] cnt;
		logic mem_rd;
		logic [15:0] mem_addr;
		logic busy;
		logic done;
		cam_pkg::cam_res_t res;
	} cam_st_t;

	cam_st_t st_q;
	cam_st_t st_d;

	assign mem_rd = st_q.mem_rd;
	assign mem_addr = st_q.mem_addr;
	assign busy = st_q.busy;
	assign done = st_q.done;
	assign res = st_q.res;

	////////////////////////////////////////////////////////////////////////////
	// Next state.

	localparam int REL_SIGN = cam_pkg::REL_SIGN_BIT;

	always_comb begin
		logic [15:0] acc_n;
		logic [15:0] next_pc;
		logic [1:0] nop;
		logic [1:0] nptr;
		acc_n = st_q.acc;
		next_pc = cam_pkg::RST_WORD;
		nop = op_bytes(st_q.rq.mode);
		nptr = ptr_bytes(st_q.rq.mode);
		st_d = st_q;
		st_d.done = 1'b0;
		unique case (st_q.state)
			cam_pkg::ST_IDLE: begin
				if (req_valid) begin
					st_d.rq = req;
					st_d.acc = cam_pkg::RST_WORD;
					st_d.rel = cam_pkg::RST_BYTE;
					st_d.cnt = 2'h0;
					// Prefix 90 or 91, on any mode, selects the second index register.
					if (req.has_pre && (req.pre == cam_pkg::PFX_SECOND_INDEX ||
						req.pre == cam_pkg::PFX_IND_SECOND)) begin
						st_d.idx = req.idx_y;
					end else begin
						st_d.idx = req.idx_x;
					end
					if (req.rmw && is_long(req.mode)) begin
						// No long form exists for these, so nothing is fetched.
						st_d.res = '0;
						st_d.res.illegal = 1'b1;
						st_d.res.next_pc = req.pc;
						st_d.res.length = cam_pkg::OPCODE_LEN;
						st_d.done = 1'b1;
					end else if (op_bytes(req.mode) == 2'h0) begin
						st_d.state = cam_pkg::ST_CALC;
						st_d.busy = 1'b1;
					end else begin
						st_d.state = cam_pkg::ST_FETCH;
						st_d.busy = 1'b1;
						st_d.mem_rd = 1'b1;
						st_d.mem_addr = req.pc;
					end
				end
			end
			cam_pkg::ST_FETCH: begin
				if (mem_ack) begin
					if (has_rel(st_q.rq.mode) && st_q.cnt == nop - 2'h1) begin
						st_d.rel = mem_rdata;
					end else begin
						acc_n = {st_q.acc[7:0], mem_rdata};
						st_d.acc = acc_n;
					end
					if (st_q.cnt == nop - 2'h1) begin
						st_d.cnt = 2'h0;
						if (nptr != 2'h0) begin
							// Pointers live in page zero; the pointer address is one byte.
							st_d.mem_addr = {cam_pkg::PAGE_ZERO_HI, acc_n[7:0]};
							st_d.acc = cam_pkg::RST_WORD;
							st_d.state = cam_pkg::ST_PTR;
						end else begin
							// No pointer follows, so the read drops with the last operand byte.
							st_d.mem_rd = 1'b0;
							st_d.state = cam_pkg::ST_CALC;
						end
					end else begin
						st_d.cnt = st_q.cnt + 2'h1;
						st_d.mem_addr = st_q.mem_addr + 16'h0001;
					end
				end
			end
			cam_pkg::ST_PTR: begin
				if (mem_ack) begin
					if (st_q.rq.mode == cam_pkg::M_REL_IND) begin
						st_d.rel = mem_rdata;
					end else begin
						st_d.acc = {st_q.acc[7:0], mem_rdata};
					end
					if (st_q.cnt == nptr - 2'h1) begin
						st_d.mem_rd = 1'b0;
						st_d.cnt = 2'h0;
						st_d.state = cam_pkg::ST_CALC;
					end else begin
						st_d.cnt = st_q.cnt + 2'h1;
						// A word pointer at the page end wraps inside page zero.
						st_d.mem_addr = {cam_pkg::PAGE_ZERO_HI, st_q.mem_addr[7:0] + 8'h01};
					end
				end
			end
			cam_pkg::ST_CALC: begin
				next_pc = st_q.rq.pc + {14'h0000, nop};
				st_d.res.illegal = 1'b0;
				st_d.res.next_pc = next_pc;
				// Any prefix byte costs one more byte of instruction length.
				st_d.res.length = cam_pkg::OPCODE_LEN + {1'b0, nop} + {2'b00, st_q.rq.has_pre};
				st_d.res.imm = st_q.acc[7:0];
				st_d.res.target = next_pc + {{8{st_q.rel[REL_SIGN]}}, st_q.rel};
				st_d.res.ea = form_ea(st_q.rq.mode, st_q.acc, st_q.idx);
				st_d.done = 1'b1;
				st_d.busy = 1'b0;
				st_d.state = cam_pkg::ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers; the clock enable freezes everything.

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

endmodule

// ---- testbench/cam_addr_decode_props.sv ----
// Port checker for the operand addressing decoder.
`timescale 1ns/1ns
module cam_addr_decode_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic req_valid,
	input wire cam_pkg::cam_req_t req,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	input wire logic busy,
	input wire logic done,
	input wire cam_pkg::cam_res_t res
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// The taken request is kept so each answer is judged against its own mode.
	cam_pkg::cam_req_t rq_q;
	logic tk;
	assign tk = ce && req_valid && !busy;
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			rq_q <= '0;
		else if (tk)
			rq_q <= req;
	page_zero_a:
	assert property (done && rq_q.mode == cam_pkg::M_DIR_SHORT |-> res.ea[15:8] == 8'h00) else $error("ea off page");
	long_rmw_a:
	assert property (done && rq_q.rmw && rq_q.mode inside {cam_pkg::M_DIR_LONG, cam_pkg::M_IDX_LONG}
		|-> res.illegal) else $error("long rmw taken");
	inh_len_a:
	assert property (done && rq_q.mode == cam_pkg::M_INHERENT |-> res.length == 3'h1 + 3'(rq_q.has_pre))
		else $error("inherent length");
	no_fetch_a:
	assert property (tk && req.mode == cam_pkg::M_IDX_NONE |=> !mem_rd ##1 done && !mem_rd) else $error("no-offset fetch");
	long_addr_a:
	assert property (tk && req.mode == cam_pkg::M_DIR_LONG && !req.rmw |=> mem_rd && mem_addr == $past(req.pc))
		else $error("long address");
	ptr_page_a:
	assert property (mem_ack && rq_q.mode == cam_pkg::M_IND_SHORT && mem_addr == rq_q.pc
		|=> mem_rd && mem_addr == {8'h00, $past(mem_rdata)}) else $error("pointer address");
	addr_hold_a:
	assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr)) else $error("read dropped");
	done_bound_a:
	assert property (tk |-> ##[1:16] done) else $error("no answer");
	busy_span_a:
	assert property (tk |=> busy != done) else $error("busy after take");
	cover property (done && res.illegal);
	cover property (done && rq_q.mode == cam_pkg::M_IND_LONG);
	cover property (mem_rd && !mem_ack);
endmodule
bind cam_addr_decode cam_addr_decode_props u_props (.*);

// ---- testbench/cam_mem.sv ----
// Memory space model answering the decoder's byte reads.
`timescale 1ns/1ns
module cam_mem (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic slow,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	logic tgl_q;
	logic [7:0] last_q;
	// Between answers the data lines change every cycle, so a stale byte never matches.
	always_ff @(posedge clk_sys or posedge rst)
		if (rst) begin
			tgl_q <= 1'b0;
			last_q <= 8'h00;
		end else begin
			tgl_q <= !tgl_q;
			last_q <= mem_rdata;
		end
	assign mem_ack = mem_rd && (!slow || tgl_q);
	assign mem_rdata = mem_ack ? mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3C : ~last_q;
endmodule

// ---- testbench/cam_addr_decode_bench.sv ----
// Self-checking bench for the operand addressing decoder.
`timescale 1ns/1ns
module cam_addr_decode_bench;
	logic clk_sys = 0, rst = 1, ce = 1, req_valid = 0, slow = 0, mem_ack, mem_rd, busy, done;
	logic [7:0] mem_rdata;
	logic [15:0] mem_addr;
	cam_pkg::cam_req_t req = '0;
	cam_pkg::cam_res_t res;
	int n_mismatch = 0, check_count = 0, seed = 6;
	always #4 clk_sys = !clk_sys;
	cam_addr_decode DUT (.*);
	cam_mem u_mem (.*);
	function automatic logic [15:0] md(logic [15:0] a);
		return {8'h00, a[7:0] ^ a[15:8] ^ 8'h3C};
	endfunction
	task automatic chk(string nm, logic [15:0] x, logic [15:0] g);
		check_count++;
		if (g !== x) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic run(int n);
		cam_pkg::cam_req_t r;
		cam_pkg::cam_res_t x;
		logic [15:0] ix, b0, b1, p0, p1, wp;
		int k, ob;
		repeat (n) begin
			r = {5'($unsigned($random(seed)) % 17), 1'($random(seed)), 8'h90 + 8'($unsigned($random(seed)) % 3),
				1'(($random(seed) & 3) == 0), 24'($random(seed)), 8'($random(seed))};
			x = '0;
			ix = (r.has_pre && r.pre != 8'h92) ? 16'(r.idx_y) : 16'(r.idx_x);
			ob = r.mode inside {cam_pkg::M_INHERENT, cam_pkg::M_IDX_NONE} ? 0 : r.mode inside {cam_pkg::M_DIR_LONG,
				cam_pkg::M_IDX_LONG, cam_pkg::M_BIT_DIR_REL, cam_pkg::M_BIT_IND_REL} ? 2 : 1;
			b0 = md(r.pc);
			b1 = md(r.pc + 16'h0001);
			p0 = md(b0);
			p1 = md({8'h00, b0[7:0] + 8'h01});
			wp = {p0[7:0], p1[7:0]};
			x.length = 3'(1 + r.has_pre + ob);
			x.next_pc = r.pc + 16'(ob);
			x.imm = b0[7:0];
			case (r.mode)
				cam_pkg::M_DIR_SHORT, cam_pkg::M_BIT_DIR, cam_pkg::M_BIT_DIR_REL: x.ea = b0;
				cam_pkg::M_DIR_LONG: x.ea = {b0[7:0], b1[7:0]};
				cam_pkg::M_IDX_NONE: x.ea = ix;
				cam_pkg::M_IDX_SHORT: x.ea = b0 + ix;
				cam_pkg::M_IDX_LONG: x.ea = {b0[7:0], b1[7:0]} + ix;
				cam_pkg::M_IND_SHORT, cam_pkg::M_BIT_IND, cam_pkg::M_BIT_IND_REL: x.ea = p0;
				cam_pkg::M_IND_LONG: x.ea = wp;
				cam_pkg::M_INDIDX_SHORT: x.ea = p0 + ix;
				cam_pkg::M_INDIDX_LONG: x.ea = wp + ix;
				default: x.ea = 16'h0000;
			endcase
			b1 = r.mode == cam_pkg::M_REL_DIR ? b0 : r.mode == cam_pkg::M_REL_IND ? p0 : b1;
			x.target = x.next_pc + {{8{b1[7]}}, b1[7:0]};
			if (r.rmw && r.mode inside {cam_pkg::M_DIR_LONG, cam_pkg::M_IDX_LONG, cam_pkg::M_IND_LONG,
				cam_pkg::M_INDIDX_LONG}) begin
				x = '0;
				x.illegal = 1'b1;
				x.length = 3'h1;
				x.next_pc = r.pc;
			end
			@(posedge clk_sys);
			req_valid <= 1'b1;
			req <= r;
			@(posedge clk_sys);
			req_valid <= 1'b0;
			#1;
			for (k = 0; k < 40 && done !== 1'b1; k++) begin
				@(posedge clk_sys);
				#1;
			end
			if (k == 40) begin
				n_mismatch++;
				tally_and_finish();
			end
			chk("ea", x.ea, res.ea);
			chk("length", 16'(x.length), 16'(res.length));
			chk("next_pc", x.next_pc, res.next_pc);
			chk("illegal", 16'(x.illegal), 16'(res.illegal));
			chk("busy", 16'h0000, 16'(busy));
			if (r.mode inside {cam_pkg::M_REL_DIR, cam_pkg::M_REL_IND, cam_pkg::M_BIT_DIR_REL, cam_pkg::M_BIT_IND_REL})
				chk("target", x.target, res.target);
			if (r.mode == cam_pkg::M_IMMEDIATE)
				chk("imm", 16'(x.imm), 16'(res.imm));
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		run(300);
		$display("prompt memory test done");
		slow <= 1'b1;
		run(300);
		$display("slow memory test done");
		tally_and_finish();
	end
endmodule
